// ===== hw/lower_limit_track.sv
// lower limit fail status per channel: sense plus four calculation channels
// assumes fail/pass pulses come once per measurement from the limit checkers
module lower_limit_track (
	input  wire logic       clk_i,       // system clock
	input  wire logic       rst_b_i,     // async reset, active low
	input  wire logic [4:0] meas_done_i, // measurement made, per channel
	input  wire logic [4:0] test_en_i,   // limit test enabled, per channel
	input  wire logic [4:0] test_fail_i, // lower limit failed, per channel
	output logic [4:0]      fail_o       // held fail status per channel
);
	logic [4:0] fail_ff, nxt_fail;

	// set on fail, clear only on an enabled passing measurement
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			nxt_fail[i] = fail_ff[i];
			if (test_fail_i[i]) begin
				nxt_fail[i] = 1'b1;
			end else if (meas_done_i[i] && test_en_i[i]) begin
				nxt_fail[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fail_ff <= 5'h00;
		end else begin
			fail_ff <= nxt_fail;
		end
	end

	assign fail_o = fail_ff;
endmodule

// ===== hw/status_bank.sv
// status reporting bank: device, operation, calibrating and lower limit fail sets
// assumes an upstream parser issues one-cycle requests with the set already selected

module status_bank (
	input  wire logic                  clk_i,           // system clock, 20 MHz
	input  wire logic                  rst_b_i,         // async power-on reset, active low
	input  wire status_pkg::host_req_t req_i,           // decoded status command
	input  wire logic                  preset_i,        // status preset command pulse
	input  wire logic                  clear_status_i,  // clear-status command pulse
	input  wire logic                  nvmem_fail_i,    // nonvolatile memory failed
	input  wire logic                  cal_start_i,     // zeroing, calibration or cal-all starts
	input  wire logic                  cal_end_i,       // zeroing or calibration finished
	input  wire logic                  meas_sum_i,      // measuring summary from its set
	input  wire logic                  trig_sum_i,      // trigger wait summary from its set
	input  wire logic                  sense_sum_i,     // sense summary from its set
	input  wire logic                  upper_sum_i,     // upper limit fail summary
	input  wire logic [4:0]            meas_done_i,     // measurement made per channel
	input  wire logic [4:0]            test_en_i,       // lower limit test enabled per channel
	input  wire logic [4:0]            test_fail_i,     // lower limit failed per channel
	output logic                       rsp_valid_o,     // read answer valid, one cycle
	output logic [15:0]                rsp_data_o,      // read answer, 0 to 32767
	output logic                       oper_summary_o   // enabled operation events present
);
	localparam int N = status_pkg::NUM_SETS;

	// calibrating state
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b01,
		CAL_BUSY = 2'b10
	} cal_state_t;

	cal_state_t           cal_ff, nxt_cal;
	logic                 rsp_valid_ff, nxt_rsp_valid;
	logic [15:0]          rsp_data_ff, nxt_rsp_data;
	logic [4:0]           lower_fail;
	logic [15:0]          cond  [N];
	logic [15:0]          used  [N];
	logic [15:0]          event_w [N];
	status_pkg::set_cfg_t cfg   [N];
	status_pkg::set_cfg_t preset_val [N];
	logic [N-1:0]         summ;
	logic [N-1:0]         hit, ev_rd, en_wr, ntr_wr, ptr_wr;

	// calibrating status tracks start and finish
	always_comb begin
		case (cal_ff)
			CAL_IDLE: nxt_cal = cal_start_i ? CAL_BUSY : CAL_IDLE;
			CAL_BUSY: nxt_cal = (cal_end_i && !cal_start_i) ? CAL_IDLE : CAL_BUSY;
			default:  nxt_cal = CAL_IDLE;
		endcase
	end

	lower_limit_track u_lower (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.meas_done_i (meas_done_i),
		.test_en_i   (test_en_i),
		.test_fail_i (test_fail_i),
		.fail_o      (lower_fail)
	);

	// condition words, each bit at its documented weight
	always_comb begin
		cond[status_pkg::SET_DEVICE] = 16'h0000;
		cond[status_pkg::SET_DEVICE][status_pkg::DEV_SENSOR_ERR_BIT] = nvmem_fail_i;
		cond[status_pkg::SET_CALIB] = 16'h0000;
		cond[status_pkg::SET_CALIB][status_pkg::CALIB_STATUS_BIT] = (cal_ff == CAL_BUSY);
		cond[status_pkg::SET_LOWER] = 16'h0000;
		cond[status_pkg::SET_LOWER][status_pkg::LOWER_SENSE_BIT] = lower_fail[0];
		cond[status_pkg::SET_LOWER][status_pkg::LOWER_CALC_LSB +: status_pkg::NUM_CALC] = lower_fail[4:1];
		cond[status_pkg::SET_OPERATION] = 16'h0000;
		// summaries of child sets feed the operation condition
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_CALIB_BIT] = summ[status_pkg::SET_CALIB];
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_MEAS_BIT]  = meas_sum_i;
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_TRIG_BIT]  = trig_sum_i;
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_SENSE_BIT] = sense_sum_i;
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_LOWER_BIT] = summ[status_pkg::SET_LOWER];
		cond[status_pkg::SET_OPERATION][status_pkg::OPER_UPPER_BIT] = upper_sum_i;
	end

	// fixed per-set tables: used bits and preset values
	always_comb begin
		used[status_pkg::SET_DEVICE]    = status_pkg::DEV_USED_MASK;
		used[status_pkg::SET_OPERATION] = status_pkg::OPER_USED_MASK;
		used[status_pkg::SET_CALIB]     = status_pkg::CALIB_USED_MASK;
		used[status_pkg::SET_LOWER]     = status_pkg::LOWER_USED_MASK;
		for (int i = 0; i < N; i++) begin
			preset_val[i].ptr    = status_pkg::PRESET_ALL_ONES;
			preset_val[i].ntr    = status_pkg::PRESET_ALL_ZEROS;
			// preset masks top-level sets and opens summary sets; reset masks every set
			preset_val[i].enable = (i == status_pkg::SET_DEVICE || i == status_pkg::SET_OPERATION) ?
				status_pkg::PRESET_ALL_ZEROS : status_pkg::PRESET_ALL_ONES;
		end
	end

	// command decode into per-set strobes
	always_comb begin
		for (int i = 0; i < N; i++) begin
			hit[i]    = req_i.valid && (req_i.set_sel == status_pkg::set_sel_t'(i));
			ev_rd[i]  = hit[i] && (req_i.cmd == status_pkg::CMD_EVENT_RD);
			en_wr[i]  = hit[i] && (req_i.cmd == status_pkg::CMD_ENAB_WR);
			ntr_wr[i] = hit[i] && (req_i.cmd == status_pkg::CMD_NTR_WR);
			ptr_wr[i] = hit[i] && (req_i.cmd == status_pkg::CMD_PTR_WR);
		end
	end

	// one register set per status set, same commands on each
	for (genvar g = 0; g < N; g++) begin : g_set
		status_reg_set u_set (
			.clk_i        (clk_i),
			.rst_b_i      (rst_b_i),
			.used_mask_i  (used[g]),
			.cond_i       (cond[g]),
			.preset_i     (preset_i),
			.preset_val_i (preset_val[g]),
			.clear_ev_i   (clear_status_i),
			.ev_rd_i      (ev_rd[g]),
			.en_wr_i      (en_wr[g]),
			.ntr_wr_i     (ntr_wr[g]),
			.ptr_wr_i     (ptr_wr[g]),
			.wdata_i      (req_i.wdata),
			.cond_o       (),
			.event_o      (event_w[g]),
			.cfg_o        (cfg[g]),
			.summary_o    (summ[g])
		);
	end

	// read answer mux; writes give no answer
	always_comb begin
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data  = rsp_data_ff;
		if (req_i.valid) begin
			case (req_i.cmd)
				status_pkg::CMD_COND_RD: begin
					nxt_rsp_valid = 1'b1;
					// live masked condition, reading has no side effect
					nxt_rsp_data  = cond[req_i.set_sel] & used[req_i.set_sel] & status_pkg::LOW15_MASK;
				end
				status_pkg::CMD_EVENT_RD: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = event_w[req_i.set_sel] & status_pkg::LOW15_MASK;
				end
				status_pkg::CMD_ENAB_RD: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = cfg[req_i.set_sel].enable & status_pkg::LOW15_MASK;
				end
				status_pkg::CMD_NTR_RD: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = cfg[req_i.set_sel].ntr & status_pkg::LOW15_MASK;
				end
				status_pkg::CMD_PTR_RD: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = cfg[req_i.set_sel].ptr & status_pkg::LOW15_MASK;
				end
				default: begin
					nxt_rsp_valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_ff       <= CAL_IDLE;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= 16'h0000;
		end else begin
			cal_ff       <= nxt_cal;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff  <= nxt_rsp_data;
		end
	end

	assign rsp_valid_o    = rsp_valid_ff;
	assign rsp_data_o     = rsp_data_ff;
	assign oper_summary_o = summ[status_pkg::SET_OPERATION];
endmodule

// ===== hw/status_pkg.sv
// package for the status register bank: set and command codes, bit positions, preset values
// assumes a command decoder upstream turns host status commands into set/command/data strobes
package status_pkg;

	// status register sets held by this bank
	typedef enum logic [1:0] {
		SET_DEVICE    = 2'h0,
		SET_OPERATION = 2'h1,
		SET_CALIB     = 2'h2,
		SET_LOWER     = 2'h3
	} set_sel_t;

	// register set commands; a bare set access decodes as an event read
	typedef enum logic [2:0] {
		CMD_COND_RD = 3'h0,
		CMD_EVENT_RD = 3'h1,
		CMD_ENAB_WR = 3'h2,
		CMD_ENAB_RD = 3'h3,
		CMD_NTR_WR  = 3'h4,
		CMD_NTR_RD  = 3'h5,
		CMD_PTR_WR  = 3'h6,
		CMD_PTR_RD  = 3'h7
	} cmd_t;

	localparam int NUM_SETS = 4;
	localparam int REG_W    = 16;

	// host request carried as one bundle
	typedef struct packed {
		logic        valid;
		set_sel_t    set_sel;
		cmd_t        cmd;
		logic [15:0] wdata;
	} host_req_t;

	// filter and mask state of one set
	typedef struct packed {
		logic [15:0] enable;
		logic [15:0] ptr;
		logic [15:0] ntr;
	} set_cfg_t;

	// bits with a function in each set
	localparam logic [15:0] DEV_USED_MASK   = 16'h0008;
	localparam logic [15:0] OPER_USED_MASK  = 16'h1c31;
	localparam logic [15:0] CALIB_USED_MASK = 16'h0002;
	localparam logic [15:0] LOWER_USED_MASK = 16'h007a;
	localparam logic [15:0] LOW15_MASK      = 16'h7fff;

	// bit positions
	localparam int DEV_SENSOR_ERR_BIT = 3;
	localparam int OPER_CALIB_BIT     = 0;
	localparam int OPER_MEAS_BIT      = 4;
	localparam int OPER_TRIG_BIT      = 5;
	localparam int OPER_SENSE_BIT     = 10;
	localparam int OPER_LOWER_BIT     = 11;
	localparam int OPER_UPPER_BIT     = 12;
	localparam int CALIB_STATUS_BIT   = 1;
	localparam int LOWER_SENSE_BIT    = 1;
	localparam int LOWER_CALC_LSB     = 3;
	localparam int NUM_CALC           = 4;

	// preset values
	localparam logic [15:0] PRESET_ALL_ZEROS = 16'h0000;
	localparam logic [15:0] PRESET_ALL_ONES  = 16'h7fff;

endpackage

// ===== hw/status_reg_set.sv
// one status register set: condition, event latch, enable and both transition filters
// assumes condition bits arrive synchronous to clk_i; unused bits are masked here with used_mask_i
module status_reg_set (
	input  wire logic                       clk_i,       // system clock
	input  wire logic                       rst_b_i,     // async reset, active low
	input  wire logic [15:0]                used_mask_i, // bits with a function
	input  wire logic [15:0]                cond_i,      // live condition bits
	input  wire logic                       preset_i,    // status preset pulse
	input  wire status_pkg::set_cfg_t       preset_val_i,// values loaded on preset
	input  wire logic                       clear_ev_i,  // clear-status pulse
	input  wire logic                       ev_rd_i,     // event read of this set
	input  wire logic                       en_wr_i,     // enable write
	input  wire logic                       ntr_wr_i,    // falling filter write
	input  wire logic                       ptr_wr_i,    // rising filter write
	input  wire logic [15:0]                wdata_i,     // write value
	output logic [15:0]                     cond_o,      // condition register
	output logic [15:0]                     event_o,     // latched events
	output status_pkg::set_cfg_t            cfg_o,       // enable and filters
	output logic                            summary_o    // or of enabled events
);
	logic [15:0]          cond_ff, nxt_cond;
	logic [15:0]          event_ff, nxt_event;
	status_pkg::set_cfg_t cfg_ff, nxt_cfg;
	logic [15:0]          edge_hit;
	logic [15:0]          cond_m;

	// condition, event and filter next state
	always_comb begin
		cond_m   = cond_i & used_mask_i & status_pkg::LOW15_MASK;
		nxt_cond = cond_m;
		edge_hit = ((cond_m & ~cond_ff) & cfg_ff.ptr) | ((~cond_m & cond_ff) & cfg_ff.ntr);
		nxt_event = event_ff;
		if (ev_rd_i || clear_ev_i) begin
			nxt_event = 16'h0000;
		end
		// a new edge in the read cycle is kept, set beats clear
		nxt_event = nxt_event | edge_hit;
		nxt_cfg = cfg_ff;
		if (preset_i) begin
			nxt_cfg = preset_val_i;
		end else begin
			if (en_wr_i) begin
				nxt_cfg.enable = wdata_i & status_pkg::LOW15_MASK;
			end
			if (ntr_wr_i) begin
				nxt_cfg.ntr = wdata_i & status_pkg::LOW15_MASK;
			end
			if (ptr_wr_i) begin
				nxt_cfg.ptr = wdata_i & status_pkg::LOW15_MASK;
			end
		end
	end

	// power-on loads preset filters and clears events
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cond_ff  <= 16'h0000;
			event_ff <= 16'h0000;
			cfg_ff   <= '{enable: status_pkg::PRESET_ALL_ZEROS,
			              ptr:    status_pkg::PRESET_ALL_ONES,
			              ntr:    status_pkg::PRESET_ALL_ZEROS};
		end else begin
			cond_ff  <= nxt_cond;
			event_ff <= nxt_event;
			cfg_ff   <= nxt_cfg;
		end
	end

	assign cond_o    = cond_ff;
	assign event_o   = event_ff;
	assign cfg_o     = cfg_ff;
	assign summary_o = |(event_ff & cfg_ff.enable);
endmodule

// ===== testbench/host_model.sv
// host side: issues one status command at a time and keeps the answer
// assumes callers enter just after a rising edge
module host_model (
	input  wire logic                  clk_i,       // system clock
	input  wire logic                  rsp_valid_i, // answer strobe
	input  wire logic [15:0]           rsp_data_i,  // answer word
	output status_pkg::host_req_t      req_o        // command to the bank
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] got;
	logic        got_v;
	initial req_o = '0;
	// one-cycle request, idle cycle after so strobes never meet
	task automatic xfer(input status_pkg::set_sel_t s, input status_pkg::cmd_t c, input logic [15:0] d);
		req_o = {1'b1, s, c, d};
		@(posedge clk_i);
		#2;
		got_v = rsp_valid_i;
		got = rsp_data_i;
		req_o.valid = 1'b0;
		@(posedge clk_i);
		#2;
	endtask
endmodule

// ===== testbench/scpi_status_register_sets_bench.sv
// bench for the status bank: filter read-back, preset, condition sources, events
// assumes host_model and the bound checker are compiled first
module scpi_status_register_sets_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk_i = 1'b0;
	logic                  rst_b_i = 1'b0;
	logic                  pre = 1'b0, clr = 1'b0, nvf = 1'b0, cs = 1'b0, ce = 1'b0;
	logic [3:0]            sums = 4'h0;
	logic [4:0]            done = 5'h00, ten = 5'h00, fl = 5'h00;
	logic                  rsp_valid, oper_sum;
	logic [15:0]           rsp_data, v, e;
	status_pkg::host_req_t req;
	int                    bad_count = 0, total_checks = 0, seed = 2;
	always #25 clk_i = ~clk_i;
	status_bank dut (.clk_i, .rst_b_i, .req_i(req), .preset_i(pre), .clear_status_i(clr), .nvmem_fail_i(nvf),
		.cal_start_i(cs), .cal_end_i(ce), .meas_sum_i(sums[0]), .trig_sum_i(sums[1]), .sense_sum_i(sums[2]),
		.upper_sum_i(sums[3]), .meas_done_i(done), .test_en_i(ten), .test_fail_i(fl), .rsp_valid_o(rsp_valid),
		.rsp_data_o(rsp_data), .oper_summary_o(oper_sum));
	host_model host (.clk_i, .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .req_o(req));
	task automatic tick();
		@(posedge clk_i);
		#2;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// strobe and word compared together
	task automatic rd(input status_pkg::set_sel_t s, input status_pkg::cmd_t c, input logic [15:0] exp);
		host.xfer(s, c, 16'h0000);
		chk({host.got_v, host.got}, {1'b1, exp});
	endtask
	// k: 0 enable, 1 falling filter, 2 rising filter
	function automatic logic [15:0] cfg_exp(input int s, input int k, input bit p);
		if (k == 2) return status_pkg::PRESET_ALL_ONES;
		if (k == 0 && p && s >= 2) return status_pkg::PRESET_ALL_ONES;
		return status_pkg::PRESET_ALL_ZEROS;
	endfunction
	function automatic logic [15:0] lmap(input logic [4:0] f);
		return {9'h000, f[4:1], 1'b0, f[0], 1'b0};
	endfunction
	task automatic cfg_all(input bit p);
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 3; k++) begin
				rd(status_pkg::set_sel_t'(2'(s)), status_pkg::cmd_t'(3'(3 + 2 * k)), cfg_exp(s, k, p));
			end
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		#2;
		rst_b_i = 1'b1;
		cfg_all(1'b0);
		// every filter and mask of every set, all ones first
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 3; k++) begin
				v = (s == 0) ? 16'hffff : 16'($random(seed));
				host.xfer(status_pkg::set_sel_t'(2'(s)), status_pkg::cmd_t'(3'(2 + 2 * k)), v);
				rd(status_pkg::set_sel_t'(2'(s)), status_pkg::cmd_t'(3'(3 + 2 * k)), v & 16'h7fff);
			end
		end
		pre = 1'b1;
		tick();
		pre = 1'b0;
		cfg_all(1'b1);
		clr = 1'b1;
		tick();
		clr = 1'b0;
		cfg_all(1'b1);
		nvf = 1'b1;
		tick();
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_COND_RD, 16'h0008);
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_EVENT_RD, 16'h0008);
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_EVENT_RD, 16'h0000);
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_COND_RD, 16'h0008);
		cs = 1'b1;
		tick();
		cs = 1'b0;
		rd(status_pkg::SET_CALIB, status_pkg::CMD_COND_RD, 16'h0002);
		ce = 1'b1;
		tick();
		ce = 1'b0;
		rd(status_pkg::SET_CALIB, status_pkg::CMD_COND_RD, 16'h0000);
		sums = 4'($random(seed));
		tick();
		e = {3'h0, sums[3], 1'b0, sums[2], 4'h0, sums[1], sums[0], 4'h1};
		rd(status_pkg::SET_OPERATION, status_pkg::CMD_COND_RD, e);
		rd(status_pkg::SET_CALIB, status_pkg::CMD_EVENT_RD, 16'h0002);
		rd(status_pkg::SET_OPERATION, status_pkg::CMD_COND_RD, e & 16'hfffe);
		host.xfer(status_pkg::SET_OPERATION, status_pkg::CMD_ENAB_WR, 16'h0001);
		chk({16'h0000, oper_sum}, 17'h00001);
		clr = 1'b1;
		tick();
		clr = 1'b0;
		chk({16'h0000, oper_sum}, 17'h00000);
		rd(status_pkg::SET_OPERATION, status_pkg::CMD_EVENT_RD, 16'h0000);
		v = 16'($random(seed));
		fl = v[4:0] | 5'h01;
		tick();
		fl = 5'h00;
		rd(status_pkg::SET_LOWER, status_pkg::CMD_COND_RD, lmap(v[4:0] | 5'h01));
		ten = v[9:5];
		done = 5'h1f;
		tick();
		done = 5'h00;
		rd(status_pkg::SET_LOWER, status_pkg::CMD_COND_RD, lmap((v[4:0] | 5'h01) & ~v[9:5]));
		// falling edge only latches once its filter bit is open
		host.xfer(status_pkg::SET_DEVICE, status_pkg::CMD_NTR_WR, 16'h0008);
		nvf = 1'b0;
		tick();
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_EVENT_RD, 16'h0008);
		rd(status_pkg::SET_DEVICE, status_pkg::CMD_COND_RD, 16'h0000);
		finish_test();
	end
	// whole run is under two hundred cycles; a thousand means a hang
	initial begin
		#50000;
		bad_count++;
		finish_test();
	end
endmodule

// ===== testbench/status_bank_asserts.sv
// checker for the status bank: answer timing, masked bits, condition sources
// assumes it is bound to status_bank and sees only its ports
module status_bank_asserts (
	input wire logic                  clk_i,          // clock
	input wire logic                  rst_b_i,        // reset
	input wire status_pkg::host_req_t req_i,          // command
	input wire logic                  preset_i,       // preset
	input wire logic                  clear_status_i, // clear
	input wire logic                  nvmem_fail_i,   // memory fail
	input wire logic                  cal_start_i,    // cal start
	input wire logic                  cal_end_i,      // cal end
	input wire logic                  meas_sum_i,     // measuring
	input wire logic                  trig_sum_i,     // trigger wait
	input wire logic                  sense_sum_i,    // sense
	input wire logic                  upper_sum_i,    // upper fail
	input wire logic [4:0]            meas_done_i,    // measured
	input wire logic [4:0]            test_en_i,      // test on
	input wire logic [4:0]            test_fail_i,    // test failed
	input wire logic                  rsp_valid_o,    // answer strobe
	input wire logic [15:0]           rsp_data_o,     // answer
	input wire logic                  oper_summary_o  // summary
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        is_rd;
	logic        cond_rd;
	logic [15:0] used_m;
	// writes are the even nonzero codes
	assign is_rd = req_i.valid && (req_i.cmd[0] || req_i.cmd == status_pkg::CMD_COND_RD);
	assign cond_rd = req_i.valid && req_i.cmd == status_pkg::CMD_COND_RD;
	// bits with a function in the addressed set
	always_comb begin
		case (req_i.set_sel)
			status_pkg::SET_DEVICE:    used_m = status_pkg::DEV_USED_MASK;
			status_pkg::SET_OPERATION: used_m = status_pkg::OPER_USED_MASK;
			status_pkg::SET_CALIB:     used_m = status_pkg::CALIB_USED_MASK;
			default:                   used_m = status_pkg::LOWER_USED_MASK;
		endcase
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rd_ans; is_rd |=> rsp_valid_o; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
	property p_wr_quiet; req_i.valid && !is_rd |=> !rsp_valid_o; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
	property p_ans_src; rsp_valid_o |-> $past(is_rd); endproperty
	a_ans_src: assert property (p_ans_src) else $error("answer without read");
	property p_hold; !rsp_valid_o |-> $stable(rsp_data_o); endproperty
	a_hold: assert property (p_hold) else $error("answer word moved");
	property p_bit15; rsp_valid_o |-> !rsp_data_o[15]; endproperty
	a_bit15: assert property (p_bit15) else $error("bit 15 set");
	property p_unused; is_rd && req_i.cmd[2:1] == 2'h0 |=> (rsp_data_o & ~$past(used_m)) == 16'h0000; endproperty
	a_unused: assert property (p_unused) else $error("unused bit set");
	property p_dev_cond;
		cond_rd && req_i.set_sel == status_pkg::SET_DEVICE |=> rsp_data_o == {12'h000, $past(nvmem_fail_i), 3'h0};
	endproperty
	a_dev_cond: assert property (p_dev_cond) else $error("sensor error bit wrong");
	property p_cal_set; cal_start_i ##1 (cond_rd && req_i.set_sel == status_pkg::SET_CALIB) |=> rsp_data_o[1]; endproperty
	a_cal_set: assert property (p_cal_set) else $error("calibrating bit not set");
	property p_cal_clr;
		cal_end_i && !cal_start_i ##1 (cond_rd && req_i.set_sel == status_pkg::SET_CALIB) |=> !rsp_data_o[1];
	endproperty
	a_cal_clr: assert property (p_cal_clr) else $error("calibrating bit not cleared");
	property p_low_set; test_fail_i[0] ##1 (cond_rd && req_i.set_sel == status_pkg::SET_LOWER) |=> rsp_data_o[1]; endproperty
	a_low_set: assert property (p_low_set) else $error("lower fail bit not set");
endmodule

bind status_bank status_bank_asserts chk (.clk_i, .rst_b_i, .req_i, .preset_i, .clear_status_i, .nvmem_fail_i,
	.cal_start_i, .cal_end_i, .meas_sum_i, .trig_sum_i, .sense_sum_i, .upper_sum_i, .meas_done_i, .test_en_i,
	.test_fail_i, .rsp_valid_o, .rsp_data_o, .oper_summary_o);
